// ==== shared/fsp_regs.vh ====
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
// Word offsets on the Wishbone bus (byte addresses).
`define FSP_ADR_OPTIONS     6'h00
`define FSP_ADR_CONFIG      6'h04
`define FSP_ADR_PROTECT     6'h08
`define FSP_ADR_STATUS      6'h0c
`define FSP_ADR_KEY_LO      6'h10
`define FSP_ADR_KEY_HI      6'h14
`define FSP_ADR_IRQ_STATUS  6'h18
`define FSP_ADR_IRQ_MASK    6'h1c
// Options fields.
`define FSP_OPT_BACKDOOR_KEY_ENABLE       7
`define FSP_OPT_NORED       6
`define FSP_OPT_USED_MASK   8'hc3
`define FSP_SEC_UNSECURED   2'h2
// Configuration fields.
`define FSP_CFG_KEY_WRITE_ACCESS      5
`define FSP_CFG_MASK        8'he0
// Protection fields.
`define FSP_PROT_DIS        0
// Status fields.
`define FSP_ST_CBEF         7
`define FSP_ST_CCF          6
`define FSP_ST_PVIOL        5
`define FSP_ST_ACCERR       4
`define FSP_ST_BLANK        2
`define FSP_ST_MASK         8'hf4
// Reset values.
`define FSP_CFG_RESET       8'h00
`define FSP_STATUS_RESET    8'hc0
`define FSP_IRQ_RESET       4'h0
// Key window length in bytes.
`define FSP_KEY_BYTES       4'h8
`endif

// ==== design/fsp_key_check.v ====
`timescale 1ns/1ps
`include "fsp_regs.vh"
// Collects eight key bytes in order, compares each one as it arrives, and reports the match after the eighth.
module fsp_key_check
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wr_i,
    input  wire [2:0]  idx_i,
    input  wire [7:0]  data_i,
    input  wire [63:0] key_i,
    output reg         match_o
);
    reg [3:0] cnt_q;
    reg       ok_q;
    wire      in_order;
    wire      byte_ok;

    assign in_order = (idx_i == cnt_q[2:0]);
    assign byte_ok  = (data_i == key_i[8*idx_i +: 8]);

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q   <= 4'h0;
            ok_q    <= 1'b1;
            match_o <= 1'b0;
        end
        else
        begin
            match_o <= 1'b0;
            if (wr_i)
            begin
                // R19 compare after eight
                if (cnt_q == `FSP_KEY_BYTES - 4'h1)
                begin
                    match_o <= ok_q & byte_ok & in_order;
                    cnt_q   <= 4'h0;
                    ok_q    <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q + 4'h1;
                    ok_q  <= ok_q & byte_ok & in_order;
                end
            end
        end
    end
endmodule

// ==== design/fsp_regs.v ====
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "fsp_regs.vh"
// How it works
// R01 - Options register loads from nonvolatile option byte during each reset.
// R02 - Options register is read-only; bits 5 to 2 read zero.
// R03 - Option bit 7 enables backdoor; matching eight bytes unlock until reset.
// R04 - Only secured user firmware writes key bytes; debug writes never count.
// R05 - Option bit 6 set disables vector redirection; clear leaves it enabled.
// R06 - Security code 1:0 means unsecured; every other pattern means secured.
// R07 - While secured, block memory accesses from unsecured sources like debug.
// R08 - Security code becomes 1:0 after key match or all-blank check.
// R09 - Configuration bits 7 to 5 read/write; bits 4 to 0 zero.
// R10 - Configuration bit 5 routes key window writes: key compare or command.
// R11 - Protection register loads from nonvolatile protection byte during reset.
// R12 - Protection ignores user writes; debug writes update all eight bits.
// R13 - Select field bounds high-end protected region; protected edits refused.
// R14 - Protection bit 0 set means none; clear protects selected region.
// R15 - Status bits 3,1,0 read zero; others readable with special writes.
// R16 - Writing one to bit 7 launches; device clears, then sets when empty.
// R17 - Protected command ignored and violation flag set; write one clears.
// R18 - Access error on bad sequence, no divider, stop; write one clears.
// R19 - Key compared after all eight bytes; mismatch changes nothing.
module fsp_regs
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        background_debug_mode_i,
    input  wire [7:0]  nonvolatile_option_byte_i,
    input  wire [7:0]  nonvolatile_protection_byte_i,
    input  wire [63:0] backdoor_comparison_key_i,
    input  wire        key_win_wr_i,
    input  wire [2:0]  key_win_idx_i,
    input  wire [7:0]  key_win_data_i,
    input  wire        key_win_debug_i,
    input  wire        cmd_is_edit_i,
    input  wire [15:0] cmd_addr_i,
    input  wire        cmd_done_i,
    input  wire        cmd_blank_i,
    input  wire        cmd_buf_taken_i,
    input  wire        cmd_seq_err_i,
    input  wire        divider_loaded_i,
    input  wire        stop_entry_i,
    input  wire        mem_access_i,
    input  wire        mem_access_debug_i,
    output wire        mem_access_ok_o,
    output wire        key_win_cmd_start_o,
    output reg         cmd_launch_o,
    output wire        secured_o,
    output wire        vector_redirect_en_o,
    output wire        irq_o
);
    reg  [7:0]  opt_q;
    reg  [7:0]  cfg_q;
    reg  [7:0]  prot_q;
    reg  [7:0]  st_q;
    reg  [7:0]  st_d;
    reg  [3:0]  irq_st_q;
    reg  [3:0]  irq_mask_q;
    reg         busy_q;
    reg         load_q;

    wire        wb_req;
    wire        wr_acc;
    wire        rd_acc;
    wire        wr_cfg;
    wire        wr_prot;
    wire        wr_stat;
    wire        wr_irqs;
    wire        wr_irqm;
    wire        launch_ok;
    wire        cmd_running;
    wire        key_src_ok;
    wire        key_gate_ok;
    wire        unlock;
    wire        key_match;
    wire        key_wr;
    wire        violation;
    wire        acc_err;
    wire        launch;
    wire [3:0]  ev;
    wire [3:0]  irq_st_d;
    genvar      gi;

    // R06 secure decode
    function is_secured;
        input [1:0] code;
        begin
            is_secured = (code != `FSP_SEC_UNSECURED);
        end
    endfunction

    // R13 region check
    function in_protected;
        input [7:0] prot;
        input [15:0] addr;
        begin
            // The select field is the upper address bits of the last
            // unprotected location; everything above it is protected.
            in_protected = ~prot[`FSP_PROT_DIS] &&
                           (addr[15:9] > prot[7:1]);
        end
    endfunction

    // Register select, shared by the write paths below.
    function adr_hit;
        input [5:0] adr;
        input [5:0] target;
        begin
            adr_hit = (adr == target);
        end
    endfunction

    // Read data for one register; unmapped and key offsets read zero.
    function [7:0] rd_mux;
        input [5:0] adr;
        input [7:0] opt;
        input [7:0] cfg;
        input [7:0] prot;
        input [7:0] st;
        input [3:0] irqs;
        input [3:0] irqm;
        begin
            case (adr)
                `FSP_ADR_OPTIONS:    rd_mux = opt;
                `FSP_ADR_CONFIG:     rd_mux = cfg;
                `FSP_ADR_PROTECT:    rd_mux = prot;
                `FSP_ADR_STATUS:     rd_mux = st;
                `FSP_ADR_IRQ_STATUS: rd_mux = {4'h0, irqs};
                `FSP_ADR_IRQ_MASK:   rd_mux = {4'h0, irqm};
                default:             rd_mux = 8'h00;
            endcase
        end
    endfunction

    // A request is taken once; the registered ack masks the second edge.
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_acc = wb_req & wb_we_i & wb_sel_i[0];
    assign rd_acc = wb_req & ~wb_we_i;

    // One write strobe per register keeps the address compare in one place.
    assign wr_cfg  = wr_acc & adr_hit(wb_adr_i, `FSP_ADR_CONFIG);
    assign wr_prot = wr_acc & adr_hit(wb_adr_i, `FSP_ADR_PROTECT);
    assign wr_stat = wr_acc & adr_hit(wb_adr_i, `FSP_ADR_STATUS);
    assign wr_irqs = wr_acc & adr_hit(wb_adr_i, `FSP_ADR_IRQ_STATUS);
    assign wr_irqm = wr_acc & adr_hit(wb_adr_i, `FSP_ADR_IRQ_MASK);

    // Only the one unsecured pattern opens the part; other codes stay locked.
    assign secured_o = is_secured(opt_q[1:0]);

    // R05 redirect control
    assign vector_redirect_en_o = ~opt_q[`FSP_OPT_NORED];

    // R07 block unsecured access
    assign mem_access_ok_o = mem_access_i &
                             ~(secured_o & mem_access_debug_i);

    // R10 window routing
    assign key_win_cmd_start_o = key_win_wr_i & ~cfg_q[`FSP_CFG_KEY_WRITE_ACCESS];

    // R04 firmware only keys
    // Debug writes never reach the comparator, so a probe cannot guess keys.
    assign key_src_ok = ~key_win_debug_i & secured_o;
    // R03 key enable gate
    assign key_gate_ok = opt_q[`FSP_OPT_BACKDOOR_KEY_ENABLE] & cfg_q[`FSP_CFG_KEY_WRITE_ACCESS];
    assign key_wr = key_win_wr_i & key_src_ok & key_gate_ok;

    // The comparator sees only qualified writes; it never learns the source.
    fsp_key_check u_key
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_i    (key_wr),
        .idx_i   (key_win_idx_i),
        .data_i  (key_win_data_i),
        .key_i   (backdoor_comparison_key_i),
        .match_o (key_match)
    );

    // A launch needs the buffer empty; a write while full is dropped.
    assign launch = wr_stat & wb_dat_i[`FSP_ST_CBEF] & st_q[`FSP_ST_CBEF];
    // Only program and erase can violate; a blank check reads the array.
    assign violation = launch & cmd_is_edit_i &
                       in_protected(prot_q, cmd_addr_i);
    // R18 error causes
    // Stop only counts while a command is in flight; idle stop is harmless.
    assign cmd_running = busy_q | cmd_launch_o;
    assign acc_err = cmd_seq_err_i | (stop_entry_i & cmd_running) |
                     (launch & cmd_is_edit_i & ~divider_loaded_i);
    assign launch_ok = launch & ~violation & ~acc_err;

    // R08 unlock on match
    assign unlock = key_match | (cmd_done_i & cmd_blank_i);

    // R01 option load
    // R11 protection load
    // R12 debug write only
    // The nonvolatile bytes are read one edge after reset so they settle.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            load_q <= 1'b1;
            opt_q  <= 8'h00;
            prot_q <= 8'h00;
            cfg_q  <= `FSP_CFG_RESET;
        end
        else
        begin
            load_q <= 1'b0;
            if (load_q)
            begin
                // R02 unused bits zero
                opt_q  <= nonvolatile_option_byte_i & `FSP_OPT_USED_MASK;
                prot_q <= nonvolatile_protection_byte_i;
            end
            else
            begin
                if (unlock)
                    opt_q[1:0] <= `FSP_SEC_UNSECURED;
                if (wr_prot & background_debug_mode_i)
                    prot_q <= wb_dat_i[7:0];
            end
            // R09 config mask
            if (wr_cfg)
                cfg_q <= wb_dat_i[7:0] & `FSP_CFG_MASK;
        end
    end

    // Status next value; hardware sets win over software clears.
    always @*
    begin
        st_d = st_q;
        if (wr_stat)
        begin
            // R17 violation clear
            if (wb_dat_i[`FSP_ST_PVIOL])
                st_d[`FSP_ST_PVIOL] = 1'b0;
            // R18 error clear
            if (wb_dat_i[`FSP_ST_ACCERR])
                st_d[`FSP_ST_ACCERR] = 1'b0;
        end
        // R16 buffer flag
        if (launch_ok)
        begin
            st_d[`FSP_ST_CBEF]  = 1'b0;
            st_d[`FSP_ST_CCF]   = 1'b0;
            st_d[`FSP_ST_BLANK] = 1'b0;
        end
        if (cmd_buf_taken_i)
            st_d[`FSP_ST_CBEF] = 1'b1;
        if (cmd_done_i)
        begin
            st_d[`FSP_ST_CBEF]  = 1'b1;
            st_d[`FSP_ST_CCF]   = 1'b1;
            st_d[`FSP_ST_BLANK] = cmd_blank_i;
        end
        // R17 violation set
        if (violation)
            st_d[`FSP_ST_PVIOL] = 1'b1;
        // R18 error set
        if (acc_err)
            st_d[`FSP_ST_ACCERR] = 1'b1;
        // R15 reserved status zero
        st_d = st_d & `FSP_ST_MASK;
    end

    // Interrupt events: key match, command done, violation, access error.
    assign ev[3] = key_match;
    assign ev[2] = cmd_done_i;
    assign ev[1] = violation;
    assign ev[0] = acc_err;

    // Each interrupt status bit is sticky; a new event beats a clear.
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_irq
            assign irq_st_d[gi] = ev[gi] |
                                  (irq_st_q[gi] & ~(wr_irqs & wb_dat_i[gi]));
        end
    endgenerate

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q         <= `FSP_STATUS_RESET;
            cmd_launch_o <= 1'b0;
            irq_st_q     <= `FSP_IRQ_RESET;
            irq_mask_q   <= `FSP_IRQ_RESET;
        end
        else
        begin
            st_q         <= st_d;
            cmd_launch_o <= launch_ok;
            irq_st_q     <= irq_st_d;
            // The mask takes the low nibble only; upper lanes are ignored.
            if (wr_irqm)
                irq_mask_q <= wb_dat_i[3:0];
        end
    end

    // Tracks a command in flight, so a stop request can be judged.
    always @(posedge clk_i)
    begin
        if (rst_i)
            busy_q <= 1'b0;
        else if (cmd_launch_o)
            busy_q <= 1'b1;
        else if (cmd_done_i)
            busy_q <= 1'b0;
    end

    // Level output; it stays high until software clears the status bit or its mask bit.
    assign irq_o = |(irq_st_q & irq_mask_q);

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            // Data is zero outside a read so a stale value never leaks.
            if (rd_acc)
                wb_dat_o <= {24'h000000, rd_mux(wb_adr_i, opt_q, cfg_q,
                                                prot_q, st_q, irq_st_q,
                                                irq_mask_q)};
            else
                wb_dat_o <= 32'h00000000;
        end
    end
endmodule

// ==== bench/fsp_regs_props.sv ====
`timescale 1ns/1ps
module fsp_regs_props
(
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [5:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire [7:0]  nonvolatile_option_byte_i,
    input wire        mem_access_i,
    input wire        mem_access_debug_i,
    input wire        mem_access_ok_o,
    input wire        key_win_wr_i,
    input wire        key_win_cmd_start_o,
    input wire        cmd_launch_o,
    input wire        secured_o,
    input wire        vector_redirect_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd = wb_ack_o && !wb_we_i;
    wire go = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 6'h0c
              && wb_dat_i[7];
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_pulse: assert property (s_req |=> s_ans)
        else $error("ack is not one pulse one cycle after request");
    a_opt_zero_bits: assert property (
        rd && wb_adr_i == 6'h00 |-> wb_dat_o[5:2] == 4'h0)
        else $error("options unused bits not zero");
    a_sec_decode: assert property (
        rd && wb_adr_i == 6'h00 |-> secured_o == (wb_dat_o[1:0] != 2'h2))
        else $error("secured output disagrees with code");
    a_redirect_bit: assert property (
        rd && wb_adr_i == 6'h00 |-> vector_redirect_en_o == !wb_dat_o[6])
        else $error("redirect output disagrees with option bit");
    a_cfg_low_zero: assert property (
        rd && wb_adr_i == 6'h04 |-> wb_dat_o[4:0] == 5'h00)
        else $error("configuration low bits not zero");
    a_stat_zero_bits: assert property (
        rd && wb_adr_i == 6'h0c |->
        wb_dat_o[3] == 1'b0 && wb_dat_o[1:0] == 2'h0)
        else $error("status fixed bits not zero");
    a_mem_block: assert property (mem_access_ok_o ==
        (mem_access_i && !(secured_o && mem_access_debug_i)))
        else $error("memory access gate wrong");
    a_key_cmd_src: assert property (
        key_win_cmd_start_o |-> key_win_wr_i)
        else $error("command start without key window write");
    a_launch_cause: assert property (
        cmd_launch_o |-> $past(go) || $past(go, 2))
        else $error("launch without status write");
    a_opt_load: assert property ($fell(rst_i) |=>
        secured_o == ($past(nonvolatile_option_byte_i[1:0]) != 2'h2))
        else $error("options not loaded at reset");
endmodule
bind fsp_regs fsp_regs_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .nonvolatile_option_byte_i, .mem_access_i, .mem_access_debug_i,
    .mem_access_ok_o, .key_win_wr_i, .key_win_cmd_start_o, .cmd_launch_o,
    .secured_o, .vector_redirect_en_o);

// ==== bench/tb_fsp_regs.sv ====
`timescale 1ns/1ps
module tb_fsp_regs;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, background_debug_mode = 0, kwr = 0, kdbg = 0;
    logic edit = 1, done = 0, blank = 0, div = 1, mad = 0;
    logic [5:0]  adr = 0;
    logic [31:0] wd = 0;
    logic [7:0]  nvo = 0, nvp = 0, kd = 0, o, p;
    logic [2:0]  ki = 0;
    logic [15:0] ca = 16'hfe00;
    logic [63:0] key = 0;
    logic        a;
    wire  [31:0] rdat;
    wire         ack, mok, kcs, sec, irq, cl, vre;
    int          err_count = 0, checks = 0, nl = 0;
    logic [31:0] q[$];
    fsp_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .background_debug_mode_i(background_debug_mode), .nonvolatile_option_byte_i(nvo),
        .nonvolatile_protection_byte_i(nvp), .backdoor_comparison_key_i(key),
        .key_win_wr_i(kwr), .key_win_idx_i(ki), .key_win_data_i(kd),
        .key_win_debug_i(kdbg), .cmd_is_edit_i(edit), .cmd_addr_i(ca),
        .cmd_done_i(done), .cmd_blank_i(blank), .cmd_buf_taken_i(1'b0),
        .cmd_seq_err_i(1'b0), .divider_loaded_i(div), .stop_entry_i(1'b0),
        .mem_access_i(1'b1), .mem_access_debug_i(mad), .mem_access_ok_o(mok),
        .key_win_cmd_start_o(kcs), .cmd_launch_o(cl), .secured_o(sec),
        .vector_redirect_en_o(vre), .irq_o(irq));
    initial forever #10 clk_i = ~clk_i;
    task check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // The slave answers in one cycle, but the wait is bounded anyway.
    task wb(input logic w, input logic [5:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1; we <= w; adr <= ad; wd <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            err_count++;
            stop_test;
        end
        cyc <= 0;
        @(posedge clk_i);
    endtask
    task rd(input logic [5:0] ad, input logic [7:0] e);
        q.push_back({24'h0, e});
        wb(0, ad, 8'h00);
    endtask
    task cs(input logic e);
        @(negedge clk_i);
        check(sec, e);
        @(posedge clk_i);
    endtask
    task keys(input logic [63:0] k, input logic d);
        for (int i = 0; i < 8; i++)
        begin
            kwr <= 1; ki <= i[2:0]; kd <= k[8*i +: 8]; kdbg <= d;
            @(posedge clk_i);
        end
        kwr <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    always @(posedge clk_i)
        if (cl === 1'b1)
            nl++;
    always @(posedge clk_i)
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
            check(rdat, q.pop_front());
    initial
    begin
        void'($urandom(32'h4bbe60dc));
        key = {$urandom, $urandom};
        for (int c = 0; c < 4; c++)
        begin
            o = $urandom; o[7] = 1; o[1:0] = c[1:0]; p = $urandom;
            nvo <= o; nvp <= p; rst_i <= 1;
            repeat (5) @(posedge clk_i);
            rst_i <= 0;
            repeat (2) @(posedge clk_i);
            cs(c != 2);
            @(negedge clk_i);
            check(vre, !o[6]);
            @(posedge clk_i);
            rd(6'h00, o & 8'hc3);
        end
        wb(1, 6'h00, ~o); rd(6'h00, o & 8'hc3);
        rd(6'h08, p); wb(1, 6'h08, ~p); rd(6'h08, p);
        background_debug_mode <= 1; wb(1, 6'h08, 8'h01); background_debug_mode <= 0; rd(6'h08, 8'h01);
        wb(1, 6'h04, 8'hff); rd(6'h04, 8'he0);
        mad <= 1; @(negedge clk_i); check(mok, 1'b0);
        @(posedge clk_i); mad <= 0;
        keys(key, 1); cs(1);
        keys(~key, 0); cs(1);
        keys(key, 0); cs(0);
        rd(6'h00, (o & 8'hc0) | 8'h02);
        wb(1, 6'h04, 8'h00); kwr <= 1;
        @(negedge clk_i); check(kcs, 1'b1);
        @(posedge clk_i); kwr <= 0;
        rd(6'h0c, 8'hc0); wb(1, 6'h0c, 8'h80); rd(6'h0c, 8'h00);
        check(nl, 1);
        done <= 1; blank <= 1; @(posedge clk_i); done <= 0;
        rd(6'h0c, 8'hc4);
        background_debug_mode <= 1; wb(1, 6'h08, 8'h00); background_debug_mode <= 0;
        wb(1, 6'h0c, 8'h80); rd(6'h0c, 8'he4);
        // Mask polarity is left open, so only the change of irq is judged.
        wb(1, 6'h1c, 8'h00); @(negedge clk_i); a = irq;
        @(posedge clk_i); wb(1, 6'h1c, 8'h02);
        @(negedge clk_i); check(irq ^ a, 1'b1);
        @(posedge clk_i); wb(1, 6'h0c, 8'h20); rd(6'h0c, 8'hc4);
        wb(1, 6'h18, 8'h0f); rd(6'h18, 8'h00);
        @(negedge clk_i); check(irq, 1'b0);
        @(posedge clk_i); ca <= 16'h0000; div <= 0;
        wb(1, 6'h0c, 8'h80); rd(6'h0c, 8'hd4);
        wb(1, 6'h0c, 8'h10); rd(6'h0c, 8'hc4);
        check(nl, 1);
        stop_test;
    end
endmodule
